// [include/pop_map.svh]
// Register indices, field positions, reset values and level constants for the output path.
`ifndef POP_MAP_SVH
`define POP_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define POP_IDX_POWER 8'h04
`define POP_IDX_LMIX 8'h27
`define POP_IDX_RMIX 8'h2a
`define POP_IDX_L1VOL 8'h2e
`define POP_IDX_R1VOL 8'h2f
`define POP_IDX_L2VOL 8'h30
`define POP_IDX_R2VOL 8'h31

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POP_BIT_LCONV_PDN 7
`define POP_BIT_RCONV_PDN 6
`define POP_BIT_L1_EN 5
`define POP_BIT_R1_EN 4
`define POP_BIT_L2_EN 3
`define POP_BIT_R2_EN 2
`define POP_BIT_CONV_ROUTE 7
`define POP_BIT_BYPASS_ROUTE 6
`define POP_GAIN_HI 5
`define POP_GAIN_LO 3
`define POP_VOL_HI 5
`define POP_VOL_LO 0

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define POP_RST_POWER 8'hc0
`define POP_RST_MIX 8'h38
`define POP_RST_VOL 6'h00
`define POP_MASK_POWER 8'hfc
`define POP_MASK_MIX 8'hf8

// ----------------------------------------------------------------------------
// Level mapping: driver gain in half-dB units, mixer gain in dB
// ----------------------------------------------------------------------------
`define POP_DRV_FLOOR_HDB 8'd90
`define POP_DRV_MAX_CODE 6'h21
`define POP_MIX_TOP_DB 5'sd6

`endif

// [include/pop_pkg.sv]
// Types shared by the playback output path control block.
package pop_pkg;

   // Operating mode of the codec as seen by the output path.
   typedef enum logic [2:0] {
      POP_MODE_STANDBY = 3'h0,
      POP_MODE_RECORD = 3'h1,
      POP_MODE_REC_PLAY = 3'h2,
      POP_MODE_PLAYBACK = 3'h3,
      POP_MODE_BYPASS = 3'h6
   } pop_mode_t;

   // Control bundle for one output driver.
   typedef struct packed {
      logic enable;
      logic [5:0] code;
      logic signed [7:0] gainHalfDb;
   } pop_drv_t;

   // Control bundle for one output mixer.
   typedef struct packed {
      logic convRoute;
      logic bypassRoute;
      logic [2:0] bypassCode;
      logic signed [4:0] bypassGainDb;
   } pop_mix_t;

   // APB response held in flip-flops.
   typedef struct packed {
      logic ready;
      logic slvErr;
      logic [31:0] rdata;
   } pop_apb_rsp_t;

   // Whole state of the top module.
   typedef struct packed {
      logic [7:0] powerReg;
      logic [7:0] leftMixReg;
      logic [7:0] rightMixReg;
      logic [3:0][5:0] volReg;
      pop_apb_rsp_t rsp;
      logic leftConvRun;
      logic rightConvRun;
      logic filterRun;
      logic filterData;
      pop_mix_t leftMix;
      pop_mix_t rightMix;
      logic [3:0] drvFromLeft;
      pop_drv_t [3:0] drv;
   } pop_state_t;

endpackage

// [hdl/pop_level_map.sv]
// Maps one output driver volume code and enable to a driver control bundle.
`timescale 1ns/1ps
`default_nettype none
`include "pop_map.svh"

module pop_level_map (
   input wire logic [5:0] code,
   input wire logic enable,
   output pop_pkg::pop_drv_t drv
);

   logic [5:0] clamped;
   logic [7:0] tripled;

   // ----------------------------------------------------------------------------
   // Code to gain
   // ----------------------------------------------------------------------------

   // code to gain
   // Codes past the top step are held at the top gain so no code can exceed +4.5 dB.
   always_comb begin
      clamped = (code > `POP_DRV_MAX_CODE) ? `POP_DRV_MAX_CODE : code;
      tripled = {2'b00, clamped} + {1'b0, clamped, 1'b0}; // Three half-dB per step.
      drv.enable = enable;
      drv.code = clamped;
      drv.gainHalfDb = $signed(tripled - `POP_DRV_FLOOR_HDB);
   end

endmodule
`default_nettype wire

// [hdl/pop_output_ctrl.sv]
// Register bank and control decode for the playback output path, on an APB slave.
//
// What this block does
// - Run playback filters/converters only in playback modes.
// - Mixers and drivers enabled independently of converters.
// - Serial samples feed volume, equalizer, modulator chain.
// - Power bits 7/6 power down converters, default set.
// - Bits 5:2 enable four drivers, default off.
// - Driver code: -45 dB base, 1.5 dB steps.
// - Four independent software volume codes, bits 5:0.
// - Bit 7 routes converter into its mixer.
// - Bit 6 mixes selected analog input in.
// - Bypass gain bits 5:3, +6 dB down 3 dB.
// - Left mixer feeds left drivers, right feeds right.
`timescale 1ns/1ps
`default_nettype none
`include "pop_map.svh"

module pop_output_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] opMode,
   input wire logic playbackSerialDataIn,
   output logic leftConvPowerdown,
   output logic rightConvPowerdown,
   output logic leftConvRun,
   output logic rightConvRun,
   output logic filterRun,
   output logic filterData,
   output pop_pkg::pop_mix_t leftMix,
   output pop_pkg::pop_mix_t rightMix,
   output logic [3:0] drvFromLeft,
   output pop_pkg::pop_drv_t [3:0] drvCtrl
);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------

   pop_pkg::pop_state_t st_q;
   pop_pkg::pop_state_t st_d;
   pop_pkg::pop_drv_t [3:0] drvMapped;
   logic [3:0] drvEnable;
   logic [7:0] regIdx;
   logic addrOk;
   logic accessReq;
   logic commitWrite;
   logic [7:0] readByte;
   logic playMode;
   pop_pkg::pop_mode_t mode;

   // ----------------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------------

   // Only aligned words inside the low index range are mapped; the rest answer with an error.
   always_comb begin
      regIdx = paddr[9:2];
      addrOk = 1'b0;
      if ((paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00)) begin
         unique case (regIdx)
            `POP_IDX_POWER, `POP_IDX_LMIX, `POP_IDX_RMIX: addrOk = 1'b1;
            `POP_IDX_L1VOL, `POP_IDX_R1VOL: addrOk = 1'b1;
            `POP_IDX_L2VOL, `POP_IDX_R2VOL: addrOk = 1'b1;
            default: addrOk = 1'b0;
         endcase
      end
   end

   // The first access cycle prepares the answer; the second one, with pready high, completes.
   // One wait state keeps pready and prdata straight from flip-flops.
   assign accessReq = psel & penable & ~st_q.rsp.ready;
   assign commitWrite = psel & penable & st_q.rsp.ready & pwrite & ~st_q.rsp.slvErr & pstrb[0];

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------

   // unused bits zero
   // Unused positions are returned as zero because the stored copies never hold them.
   always_comb begin
      readByte = 8'h00;
      unique case (regIdx)
         `POP_IDX_POWER: readByte = st_q.powerReg & `POP_MASK_POWER;
         `POP_IDX_LMIX: readByte = st_q.leftMixReg & `POP_MASK_MIX;
         `POP_IDX_RMIX: readByte = st_q.rightMixReg & `POP_MASK_MIX;
         `POP_IDX_L1VOL: readByte = {2'b00, st_q.volReg[0]};
         `POP_IDX_R1VOL: readByte = {2'b00, st_q.volReg[1]};
         `POP_IDX_L2VOL: readByte = {2'b00, st_q.volReg[2]};
         `POP_IDX_R2VOL: readByte = {2'b00, st_q.volReg[3]};
         default: readByte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------------------

   // An undefined mode code is treated as standby, which keeps the converters quiet.
   always_comb begin
      mode = pop_pkg::pop_mode_t'(opMode);
      unique case (mode)
         pop_pkg::POP_MODE_PLAYBACK: playMode = 1'b1;
         pop_pkg::POP_MODE_REC_PLAY: playMode = 1'b1;
         default: playMode = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Driver level mapping
   // ----------------------------------------------------------------------------

   // driver enable bits
   // Driver order on the power register is left one, right one, left two, right two.
   assign drvEnable = {st_q.powerReg[`POP_BIT_R2_EN], st_q.powerReg[`POP_BIT_L2_EN],
                       st_q.powerReg[`POP_BIT_R1_EN], st_q.powerReg[`POP_BIT_L1_EN]};

   // per-driver gain
   // One mapper per driver; the results are registered below before leaving the block.
   for (genvar i = 0; i < 4; i++) begin : g_level
      pop_level_map u_map (
         .code(st_q.volReg[i]),
         .enable(drvEnable[i]),
         .drv(drvMapped[i])
      );
   end

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------

   always_comb begin
      st_d = st_q;

      // APB answer: ready for exactly one cycle after each first access cycle.
      st_d.rsp.ready = accessReq;
      if (accessReq) begin
         st_d.rsp.slvErr = ~addrOk;
         st_d.rsp.rdata = (pwrite | ~addrOk) ? 32'h0000_0000 : {24'h00_0000, readByte};
      end else begin
         st_d.rsp.slvErr = 1'b0;
         st_d.rsp.rdata = 32'h0000_0000;
      end

      // Register writes land on the edge that completes the transfer.
      if (commitWrite) begin
         unique case (regIdx)
            `POP_IDX_POWER: st_d.powerReg = pwdata[7:0] & `POP_MASK_POWER;
            `POP_IDX_LMIX: st_d.leftMixReg = pwdata[7:0] & `POP_MASK_MIX;
            `POP_IDX_RMIX: st_d.rightMixReg = pwdata[7:0] & `POP_MASK_MIX;
            `POP_IDX_L1VOL: st_d.volReg[0] = pwdata[`POP_VOL_HI:`POP_VOL_LO];
            `POP_IDX_R1VOL: st_d.volReg[1] = pwdata[`POP_VOL_HI:`POP_VOL_LO];
            `POP_IDX_L2VOL: st_d.volReg[2] = pwdata[`POP_VOL_HI:`POP_VOL_LO];
            `POP_IDX_R2VOL: st_d.volReg[3] = pwdata[`POP_VOL_HI:`POP_VOL_LO];
            default: st_d.powerReg = st_q.powerReg;
         endcase
      end

      // converters run gate
      // A converter runs only when the mode plays back and its power-down bit is clear.
      st_d.leftConvRun = playMode & ~st_q.powerReg[`POP_BIT_LCONV_PDN];
      st_d.rightConvRun = playMode & ~st_q.powerReg[`POP_BIT_RCONV_PDN];
      st_d.filterRun = playMode &
         (~st_q.powerReg[`POP_BIT_LCONV_PDN] | ~st_q.powerReg[`POP_BIT_RCONV_PDN]);

      // serial input to filters
      // The sample stream reaches the volume, equalizer and modulator chain only while it runs,
      // so a stopped chain sees a steady zero instead of stale toggling.
      st_d.filterData = st_d.filterRun & playbackSerialDataIn;

      st_d.leftMix.convRoute = st_q.leftMixReg[`POP_BIT_CONV_ROUTE];
      st_d.rightMix.convRoute = st_q.rightMixReg[`POP_BIT_CONV_ROUTE];

      st_d.leftMix.bypassRoute = st_q.leftMixReg[`POP_BIT_BYPASS_ROUTE];
      st_d.rightMix.bypassRoute = st_q.rightMixReg[`POP_BIT_BYPASS_ROUTE];

      // bypass gain decode
      // Gain is +6 dB minus three dB per code step, giving -15 dB at the top code.
      st_d.leftMix.bypassCode = st_q.leftMixReg[`POP_GAIN_HI:`POP_GAIN_LO];
      st_d.rightMix.bypassCode = st_q.rightMixReg[`POP_GAIN_HI:`POP_GAIN_LO];
      st_d.leftMix.bypassGainDb = `POP_MIX_TOP_DB -
         $signed({2'b00, st_q.leftMixReg[`POP_GAIN_HI:`POP_GAIN_LO]}) -
         $signed({1'b0, st_q.leftMixReg[`POP_GAIN_HI:`POP_GAIN_LO], 1'b0});
      st_d.rightMix.bypassGainDb = `POP_MIX_TOP_DB -
         $signed({2'b00, st_q.rightMixReg[`POP_GAIN_HI:`POP_GAIN_LO]}) -
         $signed({1'b0, st_q.rightMixReg[`POP_GAIN_HI:`POP_GAIN_LO], 1'b0});

      // mixer to driver feed
      // Drivers 0 and 2 take the left mixer, drivers 1 and 3 the right one.
      st_d.drvFromLeft = 4'h5;

      // independent driver enables
      // Driver enables and levels do not look at the converter run state, so the
      // analog bypass can be heard with both converters powered down.
      st_d.drv = drvMapped;
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------

   // Reset loads the documented defaults and a quiet output path.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
         st_q.powerReg <= `POP_RST_POWER;
         st_q.leftMixReg <= `POP_RST_MIX;
         st_q.rightMixReg <= `POP_RST_MIX;
         st_q.volReg <= {4{`POP_RST_VOL}};
         st_q.leftMix.bypassCode <= 3'h7;
         st_q.rightMix.bypassCode <= 3'h7;
         st_q.leftMix.bypassGainDb <= -5'sd15;
         st_q.rightMix.bypassGainDb <= -5'sd15;
         st_q.drvFromLeft <= 4'h5;
         st_q.drv[0].gainHalfDb <= -8'sd90;
         st_q.drv[1].gainHalfDb <= -8'sd90;
         st_q.drv[2].gainHalfDb <= -8'sd90;
         st_q.drv[3].gainHalfDb <= -8'sd90;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------

   // Every output is a flip-flop of the state record.
   assign prdata = st_q.rsp.rdata;
   assign pready = st_q.rsp.ready;
   assign pslverr = st_q.rsp.slvErr;
   assign leftConvPowerdown = st_q.powerReg[`POP_BIT_LCONV_PDN];
   assign rightConvPowerdown = st_q.powerReg[`POP_BIT_RCONV_PDN];
   assign leftConvRun = st_q.leftConvRun;
   assign rightConvRun = st_q.rightConvRun;
   assign filterRun = st_q.filterRun;
   assign filterData = st_q.filterData;
   assign leftMix = st_q.leftMix;
   assign rightMix = st_q.rightMix;
   assign drvFromLeft = st_q.drvFromLeft;
   assign drvCtrl = st_q.drv;

endmodule
`default_nettype wire

// [tb/pop_output_ctrl_checker.sv]
// Concurrent checks on the ports of the playback output path control block.
`timescale 1ns/1ps
`default_nettype none
module pop_output_ctrl_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] opMode,
   input wire logic playbackSerialDataIn,
   input wire logic leftConvPowerdown,
   input wire logic leftConvRun,
   input wire logic filterRun,
   input wire logic filterData,
   input wire pop_pkg::pop_mix_t leftMix,
   input wire logic [3:0] drvFromLeft,
   input wire pop_pkg::pop_drv_t [3:0] drvCtrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Bus steps
   // ----------------------------------------------------------------
   // An access cycle still waiting for its answer.
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   // A completed write with the low byte lane on, to one address.
   sequence s_wr(logic [11:0] a);
      psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence
   // The answer comes one cycle after the access is taken and stands one cycle.
   chk_ready_wait: assert property (s_taken |=> pready)
      else $error("no answer one cycle after access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   chk_err_align: assert property (s_taken and paddr[1:0] != 2'b00 |=> pslverr)
      else $error("unaligned access not refused");
   chk_rdata_upper: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_conv_pdn: assert property (s_wr(12'h010) |=> leftConvPowerdown == $past(pwdata[7]))
      else $error("left powerdown not taken from write");
   chk_drv_enable: assert property (
      s_wr(12'h010) |=> ##1 drvCtrl[0].enable == $past(pwdata[5], 2))
      else $error("driver enable not taken from write");
   chk_run_mode: assert property (
      1'b1 |=> leftConvRun == $past((opMode == 3'h2 || opMode == 3'h3) && !leftConvPowerdown))
      else $error("converter run does not follow mode");
   chk_filter_data: assert property (
      1'b1 |=> filterData == (filterRun && $past(playbackSerialDataIn)))
      else $error("filter data does not follow serial input");
   chk_mix_route: assert property (
      s_wr(12'h09c) |=> ##1 leftMix.convRoute == $past(pwdata[7], 2))
      else $error("converter route not taken from write");
   chk_mix_gain: assert property (
      leftMix.bypassGainDb == 5'(6 - 3 * leftMix.bypassCode))
      else $error("bypass gain does not match code");
   chk_drv_gain: assert property (
      drvCtrl[1].gainHalfDb == 8'(3 * drvCtrl[1].code - 90) && drvCtrl[1].code <= 6'h21)
      else $error("driver gain does not match code");
   chk_feed_map: assert property (drvFromLeft == 4'b0101)
      else $error("driver feed map wrong");
endmodule
`default_nettype wire

// [tb/pop_output_ctrl_tb.sv]
// Self-checking bench for the playback output path control block.
`timescale 1ns/1ps
`default_nettype none
module pop_output_ctrl_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, playbackSerialDataIn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [2:0] opMode = 3'h0;
   logic [31:0] prdata;
   logic pready, pslverr, leftConvPowerdown, rightConvPowerdown;
   logic leftConvRun, rightConvRun, filterRun, filterData;
   pop_pkg::pop_mix_t leftMix, rightMix;
   logic [3:0] drvFromLeft;
   pop_pkg::pop_drv_t [3:0] drvCtrl;
   logic [32:0] expQ[$];
   int miscompares = 0;
   int checks = 0;
   logic [11:0] addrs[7] = '{12'h010, 12'h09c, 12'h0a8, 12'h0b8, 12'h0bc, 12'h0c0, 12'h0c4};
   logic [7:0] rstv[7] = '{8'hc0, 8'h38, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] mask[7] = '{8'hfc, 8'hf8, 8'hf8, 8'h3f, 8'h3f, 8'h3f, 8'h3f};
   logic [5:0] codes[4] = '{6'h00, 6'h1e, 6'h21, 6'h3f};

   pop_output_ctrl u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .opMode, .playbackSerialDataIn, .leftConvPowerdown,
      .rightConvPowerdown, .leftConvRun, .rightConvRun, .filterRun, .filterData, .leftMix,
      .rightMix, .drvFromLeft, .drvCtrl);

   // ----------------------------------------------------------------
   // Clock, serial stimulus and helpers
   // ----------------------------------------------------------------
   // Free-running clock at 100 MHz.
   always #5 clk = ~clk;
   // Random serial bits keep the filter data path busy every cycle.
   always @(posedge clk) playbackSerialDataIn <= 1'($urandom);

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // One APB transfer; the expected {error, read data} is noted before it starts.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [32:0] e);
      int n;
      expQ.push_back(e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Derived outputs lag the register by one cycle, so two edges are waited.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Completion monitor: each finished transfer is matched with the oldest note.
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (expQ.size() == 0) miscompares++;
         else check({pslverr, prdata}, expQ.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      int i;
      logic [7:0] d;
      logic [5:0] c;
      void'($urandom(32'h49f0c993));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      settle();
      check(33'({leftConvPowerdown, rightConvPowerdown, drvCtrl[0].enable}), 33'h6);
      check(33'($unsigned(leftMix.bypassGainDb)), 33'h11);
      check(33'($unsigned(drvCtrl[2].gainHalfDb)), 33'ha6);
      for (i = 0; i < 7; i++) apb(1'b0, addrs[i], 32'h0, 4'hf, 33'(rstv[i]));
      // Refused places and a masked lane leave the power register alone.
      apb(1'b1, 12'h014, 32'hff, 4'hf, {1'b1, 32'h0});
      apb(1'b0, 12'h011, 32'hff, 4'hf, {1'b1, 32'h0});
      apb(1'b1, 12'h410, 32'hff, 4'hf, {1'b1, 32'h0});
      apb(1'b1, 12'h010, 32'hff, 4'he, 33'h0);
      apb(1'b0, 12'h010, 32'h0, 4'hf, 33'h0c0);
      for (i = 0; i < 7; i++) begin
         d = 8'($urandom);
         apb(1'b1, addrs[i], {24'($urandom), d}, 4'hf, 33'h0);
         apb(1'b0, addrs[i], 32'h0, 4'hf, 33'(d & mask[i]));
      end
      for (i = 0; i < 4; i++) apb(1'b1, addrs[3 + i], 32'(codes[i]), 4'hf, 33'h0);
      settle();
      for (i = 0; i < 4; i++) begin
         c = (codes[i] > 6'h21) ? 6'h21 : codes[i];
         check(33'({drvCtrl[i].code, drvCtrl[i].gainHalfDb}), 33'({c, 8'(3 * c - 90)}));
      end
      apb(1'b1, 12'h010, 32'h68, 4'hf, 33'h0);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         opMode <= 3'(i);
         settle();
         check(33'({leftConvPowerdown, rightConvPowerdown, leftConvRun, rightConvRun,
            filterRun}), (i == 2 || i == 3) ? 33'h0d : 33'h08);
         check(33'({drvCtrl[0].enable, drvCtrl[1].enable, drvCtrl[2].enable,
            drvCtrl[3].enable}), 33'ha);
      end
      // every bypass code on both mixers
      for (i = 0; i < 8; i++) begin
         d = {i[0], i[1], 3'(i), 3'h5};
         apb(1'b1, 12'h09c, 32'(d), 4'hf, 33'h0);
         apb(1'b1, 12'h0a8, 32'(~d), 4'hf, 33'h0);
         settle();
         check(33'(leftMix), 33'({d[7:3], 5'(6 - 3 * i)}));
         check(33'(rightMix), 33'({~d[7:3], 5'(6 - 3 * (7 - i))}));
      end
      check(33'(drvFromLeft), 33'h5);
      // A second reset mid-run restores the defaults.
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, 12'h010, 32'h0, 4'hf, 33'h0c0);
      settle();
      check(33'(leftMix), 33'h0f1);
      check(33'($unsigned(drvCtrl[0].gainHalfDb)), 33'ha6);
      final_report();
   end
endmodule

bind pop_output_ctrl pop_output_ctrl_checker u_chk (.clk, .sys_rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .opMode, .playbackSerialDataIn,
   .leftConvPowerdown, .leftConvRun, .filterRun, .filterData, .leftMix, .drvFromLeft,
   .drvCtrl);
`default_nettype wire
